// ---- clk_ctrl_defines.svh ----
// Offsets, field positions, reset values and timing counts of the clock control block.
// Assumes nothing; holds `define macros only.
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

// ************************************************************
// Register offsets (byte addresses) and gating bank numbers (address bits 7:4)
// ************************************************************
`define OFS_CFG 8'h00
`define OFS_CFG2 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_EN 8'h0C
`define OFS_DSLP 8'h10
`define BANK_RUN 4'h2
`define BANK_SLEEP 4'h3
`define BANK_DEEP 4'h4

// ************************************************************
// run_clock_config fields
// ************************************************************
`define CFG_CRYSTAL_VALUE_LSB 0
`define CFG_CRYSTAL_VALUE_MSB 4
`define CFG_BYPASS 5
`define CFG_USE_DIV 6
`define CFG_PLL_OFF 7
`define CFG_DIV_LSB 8
`define CFG_DIV_MSB 11
`define CFG_OSC_LSB 12
`define CFG_OSC_MSB 13
`define CFG_AUTO_GATE 14
`define CFG_RST 32'h0000_0FA0

// ************************************************************
// run_clock_config_second and deep-sleep config fields, gating reset values
// ************************************************************
`define CFG2_DIV_LSB 0
`define CFG2_DIV_MSB 5
`define CFG2_OSC_LSB 6
`define CFG2_OSC_MSB 7
`define CFG2_BYPASS 8
`define CFG2_PLL_OFF 9
`define CFG2_USE 31
`define CFG2_RST 32'h0000_033F
`define DSLP_DIV_LSB 0
`define DSLP_DIV_MSB 5
`define DSLP_INT_OSC 8
`define DSLP_RST 32'h0000_0000
`define GATE0_RST 32'h0000_0040
`define GATE_RST 32'h0000_0000

// ************************************************************
// Divider limits and timing
// ************************************************************
`define DIV_LIMIT_FIRST 6'h0F
`define DIV_LIMIT_SECOND 6'h3F
`define PLL_PREDIV 8'h02
`define PLL_VCO_MHZ 400
`define RELOCK_START 32'h0000_1200

`endif

// ---- clk_ctrl_pkg.sv ----
// Types shared by the clock control block and its bench.
// Assumes an AHB-Lite master on the same clock.
package clk_ctrl_pkg;

    // Power mode of the controller
    typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP, PM_WAKE} pwr_state_t;

    // System clock source; first four follow the oscillator source field
    typedef enum logic [2:0] {SRC_MOSC, SRC_PIOSC, SRC_PIOSC4, SRC_LFOSC, SRC_PLL} clk_src_t;

    // AHB-Lite address phase
    typedef struct packed {
        logic hsel;
        logic [7:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
    } ahb_req_t;

endpackage

// ---- pin_sync.sv ----
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes an asynchronous input pin and one clock mclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pin,
    output logic rise
);
    logic s1_q, s2_q, s3_q, level_q;
    wire agree = (s2_q == s3_q);

    // First stage feeds only the second
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) level_q <= s2_q;
        end
    end

    assign rise = agree & s2_q & ~level_q;
endmodule
`default_nettype wire

// ---- relock_counter.sv ----
// Down counter timing the PLL relock interval in main-oscillator edges.
// Assumes tick is a one-cycle pulse per oscillator edge on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
module relock_counter #(
    parameter int CNT_W = 14,
    parameter logic [CNT_W-1:0] START = CNT_W'(`RELOCK_START)
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic tick,
    output logic running,
    output logic done
);
    logic [CNT_W-1:0] count_q;
    logic running_q;

    // Refuse a zero start count at elaboration
    if (START == '0) begin : g_bad_start
        $error("relock start count must be nonzero");
    end

    // A reload restarts the full interval even mid-count
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
            running_q <= 1'b0;
        end else if (load) begin
            count_q <= START;
            running_q <= 1'b1;
        end else if (running_q && tick) begin
            count_q <= count_q - CNT_W'(1);
            if (count_q == CNT_W'(1)) running_q <= 1'b0;
        end
    end

    assign running = running_q;
    assign done = running_q & tick & ~load & (count_q == CNT_W'(1));
endmodule
`default_nettype wire

// ---- clk_ctrl.sv ----
// Clock control: PLL relock timing, system clock selection, power modes and peripheral gating.
// Assumes an AHB-Lite master on mclk, core strobes on mclk, main oscillator sampled on a pin.
//
// Overview of operation
// - PLL output unusable as clock until relock interval completes.
// - Changing crystal value starts relock; rewriting same value does not.
// - PLL leaving power-down starts relock.
// - Relock interval: down counter on main oscillator, loaded with 0x1200.
// - PLL cannot become system clock before relock counter expires.
// - Enable plus select in one write: stay on oscillator until locked.
// - Relock completion sets lock flag; raises interrupt when enabled.
// - Run mode: peripherals follow run gating, processor clocked.
// - Sleep: sleep gating if auto gating, else run gating.
// - Sleep keeps run-mode source and frequency.
// - Wait-for-interrupt enters sleep; core and memory stop until interrupt.
// - Deep-sleep: deep gating if auto gating, else run gating.
// - Deep-sleep uses main oscillator, or internal one powering main down.
// - Deep-sleep powers running PLL down, divider override capped /16 or /64.
// - Deep-sleep exit restores source and frequency before re-enabling clocks.
// - Select bit set: fields come from the second configuration register.
// - Crystal write loads PLL configuration; clearing power-down enables PLL.
// - Divisor is encoding plus one; PLL path predivides 400 MHz by 2.
// - Power-down PLL drives no output; normal mode multiplies and drives.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
module clk_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int RELOCK_W = 14,
    parameter logic [RELOCK_W-1:0] RELOCK_COUNT = RELOCK_W'(`RELOCK_START)
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire clk_ctrl_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mosc_pin,
    input wire logic wfi_instr,
    input wire logic deep_sleep_en,
    input wire logic wake_irq,
    output logic core_clk_en,
    output logic [95:0] periph_clk_en,
    output clk_ctrl_pkg::clk_src_t sys_clk_src,
    output logic [7:0] sys_divisor,
    output logic pll_power_down,
    output logic [4:0] pll_crystal_value_sel,
    output logic mosc_power_down,
    output logic int_osc_enable,
    output logic pll_lock_irq,
    output clk_ctrl_pkg::pwr_state_t power_mode
);
    import clk_ctrl_pkg::*;

    // Refuse a counter that cannot hold or time the relock interval
    if (RELOCK_W < 1 || RELOCK_W > 32) begin : g_bad_width
        $error("relock width out of range");
    end
    if (RELOCK_COUNT == '0) begin : g_bad_count
        $error("relock count must be nonzero");
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] cfg_q, cfg2_q, dslp_q;
    logic irq_en_q;
    logic [31:0] gate_q [0:8];
    logic lock_flag_q, pll_was_q, wr_pend_q;
    logic [7:0] wr_addr_q;
    pwr_state_t state_q, state_d;

    // ************************************************************
    // AHB-Lite decode
    // ************************************************************
    // Writes take one wait state so a following read sees committed data
    wire addr_phase = ahb_req.hsel & ahb_req.htrans[1] & hreadyout;
    wire we = wr_pend_q;
    wire we_cfg = we & (wr_addr_q == `OFS_CFG);
    wire we_cfg2 = we & (wr_addr_q == `OFS_CFG2);
    wire we_irq = we & (wr_addr_q == `OFS_IRQ_EN);
    wire we_dslp = we & (wr_addr_q == `OFS_DSLP);
    wire [3:0] wr_bank = wr_addr_q[7:4];
    wire [1:0] wr_word = wr_addr_q[3:2];
    wire wr_gate_ok = (wr_bank >= `BANK_RUN) & (wr_bank <= `BANK_DEEP) & (wr_word != 2'h3)
                      & (wr_addr_q[1:0] == 2'h0);
    wire [3:0] wr_idx = 4'((wr_bank - `BANK_RUN) * 4'd3 + {2'b0, wr_word});
    wire [3:0] rd_bank = ahb_req.haddr[7:4];
    wire [1:0] rd_word = ahb_req.haddr[3:2];
    wire rd_gate_ok = (rd_bank >= `BANK_RUN) & (rd_bank <= `BANK_DEEP) & (rd_word != 2'h3)
                      & (ahb_req.haddr[1:0] == 2'h0);
    wire [3:0] rd_idx = 4'((rd_bank - `BANK_RUN) * 4'd3 + {2'b0, rd_word});
    wire [31:0] status_word = {27'h0, state_q, pll_was_q, pll_power_down, lock_flag_q};
    wire [31:0] rd_data =
        (ahb_req.haddr == `OFS_CFG) ? cfg_q :
        (ahb_req.haddr == `OFS_CFG2) ? cfg2_q :
        (ahb_req.haddr == `OFS_STATUS) ? status_word :
        (ahb_req.haddr == `OFS_IRQ_EN) ? {31'h0, irq_en_q} :
        (ahb_req.haddr == `OFS_DSLP) ? dslp_q :
        rd_gate_ok ? gate_q[rd_idx] : 32'h0000_0000;

    // Bus handshake; response is always OKAY
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= addr_phase & ahb_req.hwrite;
            hreadyout <= ~(addr_phase & ahb_req.hwrite);
            if (addr_phase) wr_addr_q <= ahb_req.haddr;
            hrdata <= (addr_phase & ~ahb_req.hwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ************************************************************
    // Effective configuration
    // ************************************************************
    wire use2 = cfg2_q[`CFG2_USE];
    wire [4:0] crystal_value = cfg_q[`CFG_CRYSTAL_VALUE_MSB:`CFG_CRYSTAL_VALUE_LSB];
    wire [1:0] eff_osc = use2 ? cfg2_q[`CFG2_OSC_MSB:`CFG2_OSC_LSB] : cfg_q[`CFG_OSC_MSB:`CFG_OSC_LSB];
    wire eff_bypass = use2 ? cfg2_q[`CFG2_BYPASS] : cfg_q[`CFG_BYPASS];
    wire eff_pd = use2 ? cfg2_q[`CFG2_PLL_OFF] : cfg_q[`CFG_PLL_OFF];
    wire [5:0] eff_div = use2 ? cfg2_q[`CFG2_DIV_MSB:`CFG2_DIV_LSB] : {2'b00, cfg_q[`CFG_DIV_MSB:`CFG_DIV_LSB]};
    wire use_div = cfg_q[`CFG_USE_DIV];
    wire auto_gate = cfg_q[`CFG_AUTO_GATE];
    wire in_deep = (state_q == PM_DEEP);

    // ************************************************************
    // Relock triggers and lock flag
    // ************************************************************
    wire pd_d = eff_pd | in_deep;
    wire trig_pd = pll_power_down & ~pd_d;
    wire trig_crystal_value = we_cfg & (hwdata[`CFG_CRYSTAL_VALUE_MSB:`CFG_CRYSTAL_VALUE_LSB] != crystal_value);
    wire relock = trig_pd | trig_crystal_value;
    wire mosc_tick, relock_run, relock_done;

    pin_sync u_mosc_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(mosc_pin),
        .rise(mosc_tick)
    );

    // Interval counted on oscillator edges
    relock_counter #(
        .CNT_W(RELOCK_W),
        .START(RELOCK_COUNT)
    ) u_relock (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .load(relock),
        .tick(mosc_tick),
        .running(relock_run),
        .done(relock_done)
    );

    // Trigger clears the flag; power-down also drops it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_flag_q <= 1'b0;
        end else if (relock || pd_d) begin
            lock_flag_q <= 1'b0;
        end else if (relock_done) begin
            lock_flag_q <= 1'b1;
        end
    end

    // PLL only usable once locked and powered
    wire pll_sel = ~eff_bypass & lock_flag_q & ~pll_power_down & ~relock_run;

    // ************************************************************
    // Clock source and divisor
    // ************************************************************
    wire [7:0] div_p1 = {2'b00, eff_div} + 8'h01;
    wire [7:0] run_div = pll_sel ? (use_div ? 8'(div_p1 * `PLL_PREDIV) : `PLL_PREDIV)
                                 : (use_div ? div_p1 : 8'h01);
    wire [5:0] ds_limit = use2 ? `DIV_LIMIT_SECOND : `DIV_LIMIT_FIRST;
    wire [5:0] ds_ovr = dslp_q[`DSLP_DIV_MSB:`DSLP_DIV_LSB];
    wire [5:0] ds_enc = (ds_ovr > ds_limit) ? ds_limit : ds_ovr;
    wire [7:0] deep_div = pll_was_q ? ({2'b00, ds_enc} + 8'h01) : (use_div ? div_p1 : 8'h01);
    wire ds_int = dslp_q[`DSLP_INT_OSC];
    wire clk_src_t run_src = pll_sel ? SRC_PLL : clk_src_t'({1'b0, eff_osc});
    wire clk_src_t deep_src = ds_int ? SRC_PIOSC : SRC_MOSC;

    // ************************************************************
    // Power mode sequencing
    // ************************************************************
    // Wake waits for a relocked PLL when it was the source at entry
    always_comb begin
        state_d = state_q;
        case (state_q)
            PM_RUN: begin
                if (wfi_instr) state_d = deep_sleep_en ? PM_DEEP : PM_SLEEP;
            end
            PM_SLEEP: begin
                if (wake_irq) state_d = PM_RUN;
            end
            PM_DEEP: begin
                if (wake_irq) state_d = PM_WAKE;
            end
            PM_WAKE: begin
                if (~pll_was_q || pll_sel) state_d = PM_RUN;
            end
            default: state_d = PM_RUN;
        endcase
    end

    // Mode state and record of PLL use at deep-sleep entry
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= PM_RUN;
            pll_was_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == PM_RUN && state_d == PM_DEEP) pll_was_q <= pll_sel;
        end
    end

    // ************************************************************
    // Gating selection
    // ************************************************************
    wire [95:0] run_gate = {gate_q[2], gate_q[1], gate_q[0]};
    wire [95:0] sleep_gate = {gate_q[5], gate_q[4], gate_q[3]};
    wire [95:0] deep_gate = {gate_q[8], gate_q[7], gate_q[6]};
    wire [95:0] gate_sel =
        (state_q == PM_SLEEP) ? (auto_gate ? sleep_gate : run_gate) :
        (state_q == PM_RUN) ? run_gate :
        (auto_gate ? deep_gate : run_gate);

    // Outputs registered; sleep keeps run source and divisor
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            core_clk_en <= 1'b1;
            periph_clk_en <= 96'h0;
            sys_clk_src <= SRC_MOSC;
            sys_divisor <= 8'h01;
            pll_power_down <= 1'b1;
            mosc_power_down <= 1'b0;
            int_osc_enable <= 1'b0;
            pll_lock_irq <= 1'b0;
            power_mode <= PM_RUN;
        end else begin
            core_clk_en <= (state_q == PM_RUN);
            periph_clk_en <= gate_sel;
            sys_clk_src <= in_deep ? deep_src : run_src;
            sys_divisor <= in_deep ? deep_div : run_div;
            pll_power_down <= pd_d;
            mosc_power_down <= in_deep & ds_int;
            int_osc_enable <= in_deep ? ds_int : (run_src == SRC_PIOSC || run_src == SRC_PIOSC4);
            pll_lock_irq <= lock_flag_q & irq_en_q;
            power_mode <= state_q;
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    // Crystal field drives the PLL configuration directly
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= `CFG_RST;
            cfg2_q <= `CFG2_RST;
            dslp_q <= `DSLP_RST;
            irq_en_q <= 1'b0;
            pll_crystal_value_sel <= 5'h00;
        end else begin
            if (we_cfg) cfg_q <= hwdata;
            if (we_cfg2) cfg2_q <= hwdata;
            if (we_dslp) dslp_q <= hwdata;
            if (we_irq) irq_en_q <= hwdata[0];
            if (we_cfg) pll_crystal_value_sel <= hwdata[`CFG_CRYSTAL_VALUE_MSB:`CFG_CRYSTAL_VALUE_LSB];
        end
    end

    // Gating banks: run, sleep, deep
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 9; i++) gate_q[i] <= (i % 3 == 0) ? `GATE0_RST : `GATE_RST;
        end else if (we && wr_gate_ok) begin
            gate_q[wr_idx] <= hwdata;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_crystal_value_relock: assert property (@(posedge mclk) disable iff (sys_rst)
        trig_crystal_value |=> !lock_flag_q && relock_run)
        else $error("crystal change did not restart relock");
    a_same_crystal_value: assert property (@(posedge mclk) disable iff (sys_rst)
        we_cfg && !trig_crystal_value && !trig_pd && lock_flag_q && !pd_d |=> lock_flag_q)
        else $error("same crystal value dropped lock");
    a_pd_relock: assert property (@(posedge mclk) disable iff (sys_rst)
        trig_pd |=> relock_run && !lock_flag_q)
        else $error("power-up did not start relock");
    a_pll_gated: assert property (@(posedge mclk) disable iff (sys_rst)
        sys_clk_src == SRC_PLL |-> $past(lock_flag_q) && $past(!relock_run))
        else $error("PLL selected before relock expired");
    a_lock_irq: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(lock_flag_q) && irq_en_q |=> pll_lock_irq)
        else $error("lock interrupt missing");
    a_sleep_core: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == PM_SLEEP ##1 state_q == PM_SLEEP |-> !core_clk_en)
        else $error("core clocked in sleep");
    a_run_gating: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == PM_RUN && !we |=> periph_clk_en == $past(run_gate) && core_clk_en)
        else $error("run gating not applied");
    a_deep_pll_off: assert property (@(posedge mclk) disable iff (sys_rst)
        in_deep |=> pll_power_down && sys_divisor <= ($past(use2) ? 8'd64 : 8'd16))
        else $error("deep-sleep PLL or divider wrong");
    a_wake_order: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == PM_WAKE && pll_was_q |=> !core_clk_en && (state_q == PM_WAKE || sys_clk_src == SRC_PLL))
        else $error("clocks enabled before restore");
    a_relock_no_pll: assert property (@(posedge mclk) disable iff (sys_rst)
        relock_run |=> sys_clk_src != SRC_PLL)
        else $error("PLL selected during relock");
    a_sleep_source: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == PM_SLEEP |=> sys_clk_src == $past(run_src) && sys_divisor == $past(run_div))
        else $error("sleep changed clock");
    a_sleep_gating: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == PM_SLEEP |=> periph_clk_en == $past(auto_gate ? sleep_gate : run_gate))
        else $error("sleep gating wrong");
    a_deep_gating: assert property (@(posedge mclk) disable iff (sys_rst)
        in_deep |=> periph_clk_en == $past(auto_gate ? deep_gate : run_gate))
        else $error("deep gating wrong");
    a_deep_source: assert property (@(posedge mclk) disable iff (sys_rst)
        in_deep |=> mosc_power_down == $past(ds_int) && sys_clk_src == ($past(ds_int) ? SRC_PIOSC : SRC_MOSC))
        else $error("deep source wrong");
    a_crystal_value_load: assert property (@(posedge mclk) disable iff (sys_rst)
        we_cfg |=> pll_crystal_value_sel == $past(hwdata[`CFG_CRYSTAL_VALUE_MSB:`CFG_CRYSTAL_VALUE_LSB]))
        else $error("crystal value not loaded");
    a_pd_no_lock: assert property (@(posedge mclk) disable iff (sys_rst)
        pll_power_down |-> !lock_flag_q)
        else $error("lock held while PLL off");
endmodule
`default_nettype wire

// ---- mosc_model.sv ----
// Main oscillator model standing beside the clock control block.
// Assumes the 1ns timescale; the controller may power the crystal down.
`timescale 1ns/1ps
`default_nettype none
module mosc_model #(
    parameter real HALF_NS = 18.5
) (
    input wire logic powered_down,
    output logic mosc_pin
);
    // Free-running crystal, stopped low while powered down so no edge is counted
    initial begin
        mosc_pin = 1'b0;
        forever begin
            #(HALF_NS);
            mosc_pin = powered_down ? 1'b0 : ~mosc_pin;
        end
    end
endmodule
`default_nettype wire

// ---- pll_lock_and_power_mode_clocking_test.sv ----
// Self-checking bench of the clock control block.
// Assumes clk_ctrl_pkg and mosc_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pll_lock_and_power_mode_clocking_test;
    import clk_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    ahb_req_t ahb_req = '0;
    logic [31:0] hwdata = '0;
    logic wfi_instr = 1'b0;
    logic deep_sleep_en = 1'b0;
    logic wake_irq = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, mosc_pin, core_clk_en, pll_power_down, mosc_power_down, int_osc_enable, pll_lock_irq;
    logic [95:0] periph_clk_en;
    logic [7:0] sys_divisor;
    logic [4:0] pll_crystal_value_sel;
    clk_src_t sys_clk_src;
    pwr_state_t power_mode;
    logic [31:0] gate [3][3];
    int n_errors = 0;
    int total_checks = 0;

    // 200 MHz system clock
    always #2.5 mclk = ~mclk;

    // Short relock count keeps the run brief
    clk_ctrl #(.RELOCK_COUNT(14'd8)) clk_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .ahb_req(ahb_req),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mosc_pin(mosc_pin),
        .wfi_instr(wfi_instr), .deep_sleep_en(deep_sleep_en), .wake_irq(wake_irq),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .sys_clk_src(sys_clk_src),
        .sys_divisor(sys_divisor), .pll_power_down(pll_power_down), .pll_crystal_value_sel(pll_crystal_value_sel),
        .mosc_power_down(mosc_power_down), .int_osc_enable(int_osc_enable),
        .pll_lock_irq(pll_lock_irq), .power_mode(power_mode));
    mosc_model mosc_model_i (.powered_down(mosc_power_down), .mosc_pin(mosc_pin));

    // ****************
    // Checking helpers
    // ****************
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [95:0] exp, input logic [95:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic give_up(input string what);
        n_errors++;
        $display("[FAIL] %s expected done seen timeout", what);
        summarize();
    endtask

    function automatic logic [31:0] mkcfg(input logic [4:0] crystal_value, input logic [3:0] div, input logic autog);
        return {17'h0, autog, 2'b00, div, 1'b0, 1'b1, 1'b0, crystal_value};
    endfunction

    function automatic logic [95:0] bank(input int m);
        return {gate[m][2], gate[m][1], gate[m][0]};
    endfunction

    // PLL path divides after the fixed predivide by two
    function automatic logic [7:0] pll_div(input logic [5:0] enc);
        return ({2'b00, enc} + 8'h01) << 1;
    endfunction

    function automatic logic [7:0] osc_div(input logic [5:0] enc);
        return {2'b00, enc} + 8'h01;
    endfunction

    // ****************
    // Bus and core drivers
    // ****************
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wait_ready();
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) return;
        end
        give_up("hready");
    endtask

    // Address held until taken, then data phase until ready again
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rdat);
        ahb_req <= '{hsel: 1'b1, haddr: addr, htrans: 2'b10, hwrite: wr, hsize: 3'b010};
        wait_ready();
        ahb_req <= '0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        bus(1'b1, a, d, junk);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(name, {64'h0, exp}, {64'h0, v});
    endtask

    task automatic wait_lock();
        logic [31:0] v;
        int i;
        for (i = 0; i < 200; i++) begin
            bus(1'b0, 8'h08, 32'h0, v);
            if (v[0] === 1'b1) return;
        end
        give_up("lock");
    endtask

    task automatic nap(input logic deep);
        deep_sleep_en <= deep;
        wfi_instr <= 1'b1;
        @(posedge mclk);
        wfi_instr <= 1'b0;
        cycles(4);
        chk("core_clk_en", 96'h0, core_clk_en);
        chk("power_mode", deep ? PM_DEEP : PM_SLEEP, power_mode);
    endtask

    // Wake may wait for a relock when the PLL fed the system at entry
    task automatic wake();
        int i;
        wake_irq <= 1'b1;
        for (i = 0; i < 400 && core_clk_en !== 1'b1; i++) begin
            @(posedge mclk);
        end
        if (i == 400) give_up("wake");
        wake_irq <= 1'b0;
        deep_sleep_en <= 1'b0;
        cycles(2);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        int m, w;
        void'($urandom(14));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rdchk("cfg", 8'h00, 32'h0000_0FA0);
        rdchk("cfg2", 8'h04, 32'h0000_033F);
        rdchk("unmapped", 8'h7C, 32'h0);
        chk("hresp", 96'h0, hresp);
        chk("periph_rst", 96'h40, periph_clk_en);
        chk("pll_off", 96'h1, pll_power_down);
        for (m = 0; m < 3; m++) begin
            for (w = 0; w < 3; w++) begin
                gate[m][w] = $urandom();
                wr(8'(8'h20 + 16 * m + 4 * w), gate[m][w]);
            end
        end
        cycles(2);
        chk("run_gating", bank(0), periph_clk_en);
        rdchk("gate_rb", 8'h34, gate[1][1]);
        wr(8'h00, mkcfg(5'h0E, 4'h3, 1'b1));
        chk("src_early", SRC_MOSC, sys_clk_src);
        rdchk("lock_early", 8'h08, 32'h0);
        wait_lock();
        cycles(2);
        chk("src_pll", SRC_PLL, sys_clk_src);
        chk("divisor", pll_div(6'h03), sys_divisor);
        chk("crystal_value", 5'h0E, pll_crystal_value_sel);
        chk("pll_on", 96'h0, pll_power_down);
        wr(8'h0C, 32'h1);
        cycles(1);
        chk("irq", 96'h1, pll_lock_irq);
        wr(8'h00, mkcfg(5'h0E, 4'h3, 1'b1));
        rdchk("same_crystal_value", 8'h08, 32'h1);
        wr(8'h00, mkcfg(5'h0F, 4'h3, 1'b1));
        rdchk("new_crystal_value", 8'h08, 32'h0);
        chk("irq_drop", 96'h0, pll_lock_irq);
        chk("src_relock", SRC_MOSC, sys_clk_src);
        wait_lock();
        cycles(2);
        nap(1'b0);
        chk("sleep_gating", bank(1), periph_clk_en);
        chk("sleep_src", SRC_PLL, sys_clk_src);
        chk("sleep_div", pll_div(6'h03), sys_divisor);
        wake();
        chk("run_again", bank(0), periph_clk_en);
        wr(8'h10, 32'h0000_003F);
        nap(1'b1);
        chk("deep_gating", bank(2), periph_clk_en);
        chk("deep_src", SRC_MOSC, sys_clk_src);
        chk("deep_pll_off", 96'h1, pll_power_down);
        chk("deep_div", osc_div(6'h0F), sys_divisor);
        wake();
        chk("exit_src", SRC_PLL, sys_clk_src);
        chk("exit_div", pll_div(6'h03), sys_divisor);
        wr(8'h10, 32'h0000_0105);
        nap(1'b1);
        chk("int_osc", 96'h1, int_osc_enable);
        chk("mosc_off", 96'h1, mosc_power_down);
        wake();
        wr(8'h00, mkcfg(5'h0F, 4'h3, 1'b0));
        for (m = 0; m < 2; m++) begin
            nap(m[0]);
            chk("no_auto", bank(0), periph_clk_en);
            wake();
        end
        wr(8'h04, 32'h8000_0149);
        cycles(2);
        chk("second_src", SRC_PIOSC, sys_clk_src);
        chk("run_int_osc", 96'h1, int_osc_enable);
        chk("second_div", osc_div(6'h09), sys_divisor);
        summarize();
    end
endmodule
`default_nettype wire
